// *** pkg/prc_regs.svh ***
// Purpose: register map and reset constants
// Assumes: byte addresses on 32-bit words
// Notes: field positions are bit indices
`ifndef PRC_REGS_SVH
`define PRC_REGS_SVH
`define PRC_A_PRST 32'h4004_8004
`define PRC_A_PLLC 32'h4004_8008
`define PRC_A_PLLS 32'h4004_800C
`define PRC_A_OSCC 32'h4004_8020
`define PRC_A_ISTA 32'h4004_80F0
`define PRC_A_IMSK 32'h4004_80F4
`define PRC_B_SPI0 0
`define PRC_B_I2C 1
`define PRC_B_SPI1 2
`define PRC_B_CAN 3
`define PRC_F_PRST 3:0
`define PRC_F_FEEDBACK_DIVIDER_FIELD 4:0
`define PRC_F_PSEL 6:5
`define PRC_B_LOCK 0
`define PRC_B_BYP 0
`define PRC_B_RNG 1
`define PRC_B_GAIN 0
`define PRC_B_LOSS 1
`define PRC_F_IRQ 1:0
`define PRC_R_PRST 4'h0
`define PRC_R_FEEDBACK_DIVIDER_FIELD 5'h00
`define PRC_R_PSEL 2'h0
`define PRC_R_OSC 1'h0
`define PRC_R_LOCK 1'h0
`define PRC_R_IRQ 2'h0
`define PRC_NONSEQ 2'h2
`endif

// *** pkg/prc_pkg.sv ***
// Purpose: shared types for the config block
// Assumes: 32-bit register words
// Notes: constants live in prc_regs.svh
package prc_pkg;
    typedef logic [31:0] prc_word_t;
    typedef enum logic [1:0] {PRC_PH_IDLE, PRC_PH_WR, PRC_PH_RD} prc_phase_t;
endpackage

// *** pkg/prc_bus_if.sv ***
// Purpose: internal register access strobes
// Assumes: one clock
// Notes: slave side drives, register side answers
`timescale 1ns/1ps
interface prc_bus_if;
    logic wr_en;
    logic rd_en;
    prc_pkg::prc_word_t addr;
    prc_pkg::prc_word_t wdata;
    prc_pkg::prc_word_t rdata;
    modport slave (output wr_en, rd_en, addr, wdata, input rdata);
    modport regs (input wr_en, rd_en, addr, wdata, output rdata);
endinterface

// *** verilog/prc_ahb_slave.sv ***
// Purpose: AHB-Lite slave front end
// Assumes: single word transfers only
// Notes: writes zero wait, reads one wait
`timescale 1ns/1ps
`include "prc_regs.svh"
module prc_ahb_slave (
    input wire logic core_clk_i, // clock
    input wire logic sys_rst_i, // sync reset
    input wire logic hsel_i, // select
    input wire logic [31:0] haddr_i, // address
    input wire logic [1:0] htrans_i, // transfer type
    input wire logic hwrite_i, // write
    input wire logic hready_i, // bus ready
    input wire logic [31:0] hwdata_i, // write data
    output logic [31:0] hrdata_o, // read data
    output logic hreadyout_o, // ready out
    output logic hresp_o, // response
    prc_bus_if.slave bus // register side
);
    prc_pkg::prc_phase_t phase_reg;
    logic [31:0] addr_reg;
    logic accept;

    // address phase taken
    assign accept = hsel_i && hready_i && (htrans_i == `PRC_NONSEQ);

    // =====================================
    // data phase tracking
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            phase_reg <= prc_pkg::PRC_PH_IDLE;
        end else begin
            case (phase_reg)
                prc_pkg::PRC_PH_RD: begin
                    phase_reg <= prc_pkg::PRC_PH_IDLE; // hready low here
                end
                prc_pkg::PRC_PH_IDLE, prc_pkg::PRC_PH_WR: begin
                    if (accept) begin
                        phase_reg <= hwrite_i ? prc_pkg::PRC_PH_WR : prc_pkg::PRC_PH_RD;
                    end else begin
                        phase_reg <= prc_pkg::PRC_PH_IDLE;
                    end
                end
                default: begin
                    phase_reg <= prc_pkg::PRC_PH_IDLE;
                end
            endcase
        end
    end

    // address capture
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            addr_reg <= 32'h0000_0000;
        end else if (accept) begin
            addr_reg <= haddr_i;
        end
    end

    // one wait state on reads
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            hreadyout_o <= 1'h1;
        end else if (accept && !hwrite_i) begin
            hreadyout_o <= 1'h0;
        end else if (phase_reg == prc_pkg::PRC_PH_RD) begin
            hreadyout_o <= 1'h1;
        end
    end

    // read data and response
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            hrdata_o <= 32'h0000_0000;
            hresp_o <= 1'h0;
        end else begin
            hresp_o <= 1'h0; // always okay
            if (phase_reg == prc_pkg::PRC_PH_RD) begin
                hrdata_o <= bus.rdata;
            end
        end
    end

    // strobes toward the registers
    assign bus.wr_en = (phase_reg == prc_pkg::PRC_PH_WR);
    assign bus.rd_en = (phase_reg == prc_pkg::PRC_PH_RD);
    assign bus.addr = addr_reg;
    assign bus.wdata = hwdata_i;
endmodule

// *** verilog/prc_sysconf.sv ***
// Purpose: peripheral reset, PLL divider and
//   oscillator configuration registers
// Assumes: pll_lock_i synchronous to core_clk_i
// Notes: outputs all come from flip-flops

`timescale 1ns/1ps
`include "prc_regs.svh"

// Contract
// - A reset control bit at zero holds its peripheral in reset, at one releases it.
// - Bit 0 releases the first SPI port and resets to zero.
// - Bit 1 releases the I2C port and resets to zero.
// - Bit 2 releases the second SPI port and resets to zero.
// - Bit 3 releases the CAN controller and resets to zero.
// - Feedback field bits 4:0 divide by field plus one, 1 to 32, reset zero.
// - Post field bits 6:5 give P of 1,2,4,8, ratio twice P, reset zero.
// - Status bit 0 reads the PLL lock, read only, reset zero.
// - Bypass bit 0 feeds the PLL from the crystal pin, reset zero.
// - Range bit 1 picks 1-20 or 15-25 MHz, reset zero, sent to the oscillator.
module prc_sysconf (
    input wire logic core_clk_i, // clock
    input wire logic sys_rst_i, // sync reset

    input wire logic hsel_i, // slave select
    input wire logic [31:0] haddr_i, // address
    input wire logic [1:0] htrans_i, // transfer type
    input wire logic hwrite_i, // write
    input wire logic [2:0] hsize_i, // size, word only
    input wire logic hready_i, // bus ready
    input wire logic [31:0] hwdata_i, // write data
    output logic [31:0] hrdata_o, // read data
    output logic hreadyout_o, // slave ready
    output logic hresp_o, // response

    input wire logic pll_lock_i, // pll locked

    output logic spi_port0_reset_release_o, // 1 releases
    output logic i2c_reset_release_o, // 1 releases
    output logic spi_port1_reset_release_o, // 1 releases
    output logic can_reset_release_o, // 1 releases

    output logic [4:0] feedback_divider_field_o, // raw field
    output logic [5:0] feedback_ratio_o, // field plus one
    output logic [1:0] post_div_code_o, // raw field
    output logic [4:0] post_ratio_o, // twice P
    output logic crystal_input_pin_sel_o, // bypass
    output logic osc_range_select_o, // range
    output logic irq_o // interrupt
);

    // =====================================
    // internal bus

    prc_bus_if bus ();

    prc_ahb_slave u_slave (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .hsel_i(hsel_i),
        .haddr_i(haddr_i),
        .htrans_i(htrans_i),
        .hwrite_i(hwrite_i),
        .hready_i(hready_i),
        .hwdata_i(hwdata_i),
        .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o),
        .bus(bus)
    );

    // =====================================
    // decode

    logic wr_prst;
    logic wr_pllc;
    logic wr_oscc;
    logic wr_ista;
    logic wr_imsk;
    logic size_unused;

    // write strobes per register
    assign wr_prst = bus.wr_en && (bus.addr == `PRC_A_PRST);
    assign wr_pllc = bus.wr_en && (bus.addr == `PRC_A_PLLC);
    assign wr_oscc = bus.wr_en && (bus.addr == `PRC_A_OSCC);
    assign wr_ista = bus.wr_en && (bus.addr == `PRC_A_ISTA);
    assign wr_imsk = bus.wr_en && (bus.addr == `PRC_A_IMSK);

    // every access is taken as a word
    assign size_unused = ^hsize_i;

    // =====================================
    // peripheral reset control

    // only bits 3:0 are stored
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            {can_reset_release_o, spi_port1_reset_release_o,
             i2c_reset_release_o, spi_port0_reset_release_o} <= `PRC_R_PRST;
        end else if (wr_prst) begin
            spi_port0_reset_release_o <= bus.wdata[`PRC_B_SPI0];
            i2c_reset_release_o <= bus.wdata[`PRC_B_I2C];
            spi_port1_reset_release_o <= bus.wdata[`PRC_B_SPI1];
            can_reset_release_o <= bus.wdata[`PRC_B_CAN];
        end
    end

    // =====================================
    // pll divider control

    // raw fields; bits 31:7 are dropped
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            feedback_divider_field_o <= `PRC_R_FEEDBACK_DIVIDER_FIELD;
            post_div_code_o <= `PRC_R_PSEL;
        end else if (wr_pllc) begin
            feedback_divider_field_o <= bus.wdata[`PRC_F_FEEDBACK_DIVIDER_FIELD];
            post_div_code_o <= bus.wdata[`PRC_F_PSEL];
        end
    end

    // decoded ratios, held beside the fields
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            feedback_ratio_o <= {1'h0, `PRC_R_FEEDBACK_DIVIDER_FIELD} + 6'h01;
            post_ratio_o <= 5'h02 << `PRC_R_PSEL;
        end else if (wr_pllc) begin
            feedback_ratio_o <= {1'h0, bus.wdata[`PRC_F_FEEDBACK_DIVIDER_FIELD]} + 6'h01;
            post_ratio_o <= 5'h02 << bus.wdata[`PRC_F_PSEL];
        end
    end

    // =====================================
    // oscillator control

    // bypass steers the pll reference
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            crystal_input_pin_sel_o <= `PRC_R_OSC;
            osc_range_select_o <= `PRC_R_OSC;
        end else if (wr_oscc) begin
            crystal_input_pin_sel_o <= bus.wdata[`PRC_B_BYP];
            osc_range_select_o <= bus.wdata[`PRC_B_RNG];
        end
    end

    // =====================================
    // pll lock status

    logic lock_reg;

    // sampled lock, not writable
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            lock_reg <= `PRC_R_LOCK;
        end else begin
            lock_reg <= pll_lock_i;
        end
    end

    // =====================================
    // interrupts

    logic [1:0] irq_evt;
    logic [1:0] irq_clr;
    logic [1:0] irq_stat_reg;
    logic [1:0] irq_mask_reg;

    // lock gained and lock lost
    assign irq_evt[`PRC_B_GAIN] = pll_lock_i && !lock_reg;
    assign irq_evt[`PRC_B_LOSS] = !pll_lock_i && lock_reg;
    assign irq_clr = wr_ista ? bus.wdata[`PRC_F_IRQ] : 2'h0;

    // sticky status, a new event beats the clear
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            irq_stat_reg <= `PRC_R_IRQ;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_evt;
        end
    end

    // mask, one enables
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            irq_mask_reg <= `PRC_R_IRQ;
        end else if (wr_imsk) begin
            irq_mask_reg <= bus.wdata[`PRC_F_IRQ];
        end
    end

    // level output, registered
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            irq_o <= 1'h0;
        end else begin
            irq_o <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // =====================================
    // read back

    prc_pkg::prc_word_t rd_word;

    // unused and reserved bits read zero
    always_comb begin
        rd_word = 32'h0000_0000;
        case (bus.addr)
            `PRC_A_PRST: begin
                rd_word[`PRC_F_PRST] = {can_reset_release_o, spi_port1_reset_release_o,
                                        i2c_reset_release_o, spi_port0_reset_release_o};
            end
            `PRC_A_PLLC: begin
                rd_word[`PRC_F_FEEDBACK_DIVIDER_FIELD] = feedback_divider_field_o;
                rd_word[`PRC_F_PSEL] = post_div_code_o;
            end
            `PRC_A_PLLS: begin
                rd_word[`PRC_B_LOCK] = lock_reg;
            end
            `PRC_A_OSCC: begin
                rd_word[`PRC_B_BYP] = crystal_input_pin_sel_o;
                rd_word[`PRC_B_RNG] = osc_range_select_o;
            end
            `PRC_A_ISTA: begin
                rd_word[`PRC_F_IRQ] = irq_stat_reg;
            end
            `PRC_A_IMSK: begin
                rd_word[`PRC_F_IRQ] = irq_mask_reg;
            end
            default: begin
                rd_word[0] = 1'h0 & size_unused;
            end
        endcase
    end

    assign bus.rdata = rd_word;

    // =====================================
    // assertions

    property p_rst_vals;
        @(posedge core_clk_i) sys_rst_i |=> !spi_port0_reset_release_o && !i2c_reset_release_o
            && !spi_port1_reset_release_o && !can_reset_release_o && !crystal_input_pin_sel_o
            && !osc_range_select_o && !lock_reg && (feedback_ratio_o == 6'h01);
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("bad reset values");

    property p_spi0;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        wr_prst |=> spi_port0_reset_release_o == $past(bus.wdata[0]);
    endproperty
    a_spi0: assert property (p_spi0) else $error("spi0 release wrong");

    property p_i2c;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        wr_prst |=> i2c_reset_release_o == $past(bus.wdata[1]);
    endproperty
    a_i2c: assert property (p_i2c) else $error("i2c release wrong");

    property p_spi1_hold;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        !wr_prst |=> $stable(spi_port1_reset_release_o);
    endproperty
    a_spi1_hold: assert property (p_spi1_hold) else $error("spi1 moved");

    property p_can;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        wr_prst |=> can_reset_release_o == $past(bus.wdata[3]);
    endproperty
    a_can: assert property (p_can) else $error("can release wrong");

    property p_fb_ratio;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        wr_pllc |=> feedback_ratio_o == {1'h0, $past(bus.wdata[4:0])} + 6'h01;
    endproperty
    a_fb_ratio: assert property (p_fb_ratio) else $error("feedback ratio wrong");

    property p_post;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        wr_pllc |=> post_ratio_o == (5'h02 << $past(bus.wdata[6:5]));
    endproperty
    a_post: assert property (p_post) else $error("post ratio wrong");

    property p_lock;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        bus.rd_en && (bus.addr == `PRC_A_PLLS) |=> hrdata_o == {31'h0, $past(lock_reg)};
    endproperty
    a_lock: assert property (p_lock) else $error("lock readback wrong");

    property p_bypass;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        wr_oscc ##1 !wr_oscc |-> crystal_input_pin_sel_o == $past(bus.wdata[0]);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass wrong");

    property p_range;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        wr_oscc |=> osc_range_select_o == $past(bus.wdata[1]);
    endproperty
    a_range: assert property (p_range) else $error("range wrong");

    property p_resv;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        bus.rd_en |=> hrdata_o[31:7] == 25'h0;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bits set");

    property p_irq;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        irq_evt[0] && irq_mask_reg[0] |=> ##1 irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("lock irq missing");

endmodule

// *** dv/tb_prc_sysconf.sv ***
// Purpose: self-checking bench for the system configuration registers
// Assumes: AHB-Lite master drives single word transfers, hready tied to hreadyout
// Notes: a small integer model predicts every register and control output
`timescale 1ns/1ps
`include "prc_regs.svh"
module tb_prc_sysconf;
    // ==========================================
    // signals
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic hsel_i = 1'b0;
    logic [31:0] haddr_i = 32'h0000_0000;
    logic [1:0] htrans_i = 2'h0;
    logic hwrite_i = 1'b0;
    logic [2:0] hsize_i = 3'h2;
    logic [31:0] hwdata_i = 32'h0000_0000;
    logic pll_lock_i = 1'b0;
    logic [31:0] hrdata_o;
    logic hreadyout_o, hresp_o, irq_o;
    logic spi0_o, i2c_o, spi1_o, can_o, xtal_o, rng_o;
    logic [4:0] fb_o, pr_o;
    logic [5:0] fr_o;
    logic [1:0] pc_o;
    integer fail_count = 0;
    integer n_compared = 0;
    integer seed = 89938;
    integer cycles = 0;
    logic [31:0] m_prst, m_pll, m_osc, m_sta, m_msk, rd, w;

    // ==========================================
    // clock and design
    initial begin
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    prc_sysconf i_prc_sysconf (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
        .hready_i(hreadyout_o), .hwdata_i(hwdata_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o), .pll_lock_i(pll_lock_i), .spi_port0_reset_release_o(spi0_o),
        .i2c_reset_release_o(i2c_o), .spi_port1_reset_release_o(spi1_o), .can_reset_release_o(can_o),
        .feedback_divider_field_o(fb_o), .feedback_ratio_o(fr_o), .post_div_code_o(pc_o),
        .post_ratio_o(pr_o), .crystal_input_pin_sel_o(xtal_o), .osc_range_select_o(rng_o), .irq_o(irq_o));

    // ==========================================
    // checking and closing
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // hang guard: the whole run needs well under this many cycles
    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count = fail_count + 1;
            wrap_up();
        end
    end

    // ==========================================
    // bus master: hold each phase until hready is seen high at a rising edge
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge core_clk_i);
        hsel_i <= 1'b1;
        haddr_i <= a;
        hwrite_i <= wr;
        hsize_i <= 3'h2;
        htrans_i <= `PRC_NONSEQ;
        // address phase stands until hready is seen high at a rising edge
        @(posedge core_clk_i);
        while (hreadyout_o !== 1'b1) begin
            @(posedge core_clk_i);
        end
        htrans_i <= 2'h0;
        hwdata_i <= wr ? d : 32'h0000_0000;
        // data phase stands until hready is seen high again; read data taken there
        @(posedge core_clk_i);
        while (hreadyout_o !== 1'b1) begin
            @(posedge core_clk_i);
        end
        r = hrdata_o;
        check({31'h0, hresp_o}, 32'h0);
    endtask

    // ==========================================
    // reference model
    function automatic logic [31:0] m_read(input logic [31:0] a);
        case (a)
            `PRC_A_PRST: m_read = m_prst;
            `PRC_A_PLLC: m_read = m_pll;
            `PRC_A_PLLS: m_read = {31'h0, pll_lock_i};
            `PRC_A_OSCC: m_read = m_osc;
            `PRC_A_ISTA: m_read = m_sta;
            `PRC_A_IMSK: m_read = m_msk;
            default: m_read = 32'h0000_0000;
        endcase
    endfunction

    task automatic wr_chk(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rd);
        case (a)
            `PRC_A_PRST: m_prst = d & 32'h0000_000F;
            `PRC_A_PLLC: m_pll = d & 32'h0000_007F;
            `PRC_A_OSCC: m_osc = d & 32'h0000_0003;
            `PRC_A_ISTA: m_sta = m_sta & ~d;
            `PRC_A_IMSK: m_msk = d & 32'h0000_0003;
            default: ;
        endcase
        bus(1'b0, a, 32'h0, rd);
        check(rd, m_read(a));
    endtask

    task automatic outs;
        repeat (3) @(negedge core_clk_i);
        check({28'h0, can_o, spi1_o, i2c_o, spi0_o}, m_prst);
        check({27'h0, fb_o}, m_pll & 32'h1F);
        check({26'h0, fr_o}, (m_pll & 32'h1F) + 1);
        check({30'h0, pc_o}, (m_pll >> 5) & 32'h3);
        check({27'h0, pr_o}, 32'h2 << ((m_pll >> 5) & 32'h3));
        check({31'h0, xtal_o}, m_osc & 32'h1);
        check({31'h0, rng_o}, (m_osc >> 1) & 32'h1);
        check({31'h0, irq_o}, {31'h0, (m_sta & m_msk) != 0});
    endtask

    task automatic rd_all;
        logic [31:0] al [6];
        al = '{`PRC_A_PRST, `PRC_A_PLLC, `PRC_A_PLLS, `PRC_A_OSCC, `PRC_A_ISTA, `PRC_A_IMSK};
        foreach (al[k]) begin
            bus(1'b0, al[k], 32'h0, rd);
            check(rd, m_read(al[k]));
        end
    endtask

    task automatic do_reset;
        @(posedge core_clk_i);
        sys_rst_i <= 1'b1;
        pll_lock_i <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        m_prst = 0;
        m_pll = 0;
        m_osc = 0;
        m_sta = 0;
        m_msk = 0;
        outs();
        rd_all();
    endtask

    // ==========================================
    // main sequence
    initial begin
        do_reset();
        // walk each reset release bit, garbage in reserved bits, then release all
        for (int i = 0; i < 5; i++) begin
            w = (i < 4) ? (($random(seed) & 32'hFFFF_FFF0) | (32'h1 << i)) : 32'hFFFF_FFFF;
            wr_chk(`PRC_A_PRST, w);
            outs();
        end
        // every post code with feedback boundary values, reserved bits zero
        for (int c = 0; c < 4; c++) begin
            w = (c == 0) ? 32'h0 : (c == 3) ? 32'h1F : ($random(seed) & 32'h1F);
            wr_chk(`PRC_A_PLLC, w | (c << 5));
            outs();
        end
        // bypass and range in all four combinations
        for (int v = 0; v < 4; v++) begin
            wr_chk(`PRC_A_OSCC, ($random(seed) & 32'hFFFF_FFFC) | v);
            outs();
        end
        // lock gained: status, sticky event, masked interrupt
        wr_chk(`PRC_A_IMSK, 32'h0000_0001);
        @(posedge core_clk_i);
        pll_lock_i <= 1'b1;
        m_sta = m_sta | 32'h1;
        outs();
        wr_chk(`PRC_A_PLLS, 32'hFFFF_FFFF);
        wr_chk(`PRC_A_IMSK, 32'h0000_0002);
        outs();
        wr_chk(`PRC_A_ISTA, 32'h0000_0001);
        // lock lost raises the second event
        @(posedge core_clk_i);
        pll_lock_i <= 1'b0;
        m_sta = m_sta | 32'h2;
        outs();
        rd_all();
        wr_chk(`PRC_A_ISTA, 32'h0000_0003);
        outs();
        // unmapped address: ignored write, zero read, nothing else moves
        wr_chk(32'h4004_8010, $random(seed));
        rd_all();
        outs();
        // reset again in mid-run
        do_reset();
        wrap_up();
    end
endmodule
